// ### common/pssb_defines.vh
// register map, field positions and timing counts of the status set/clear bank
`ifndef PSSB_DEFINES_VH
`define PSSB_DEFINES_VH

`define PSSB_ADR_FORCE      5'h00
`define PSSB_ADR_DROP       5'h04
`define PSSB_ADR_HOSTEN     5'h08
`define PSSB_ADR_BEEN       5'h0C
`define PSSB_ADR_IRQ_STAT   5'h10
`define PSSB_ADR_IRQ_MASK   5'h14
`define PSSB_ADR_CTRL       5'h18

`define PSSB_BIT_HOST2LOC   31
`define PSSB_BIT_SOFT_LO    24
`define PSSB_BIT_SOFT_HI    27
`define PSSB_BIT_PARITY     6
`define PSSB_BIT_SYSERR     5
`define PSSB_BIT_MABORT     2
`define PSSB_BIT_TABORT     1

`define PSSB_STATUS_MASK    32'h8F00_0066
`define PSSB_STATUS_RESET   32'h0000_0000
`define PSSB_HWCOND_MASK    32'h0000_0066
`define PSSB_SYNC_CLKS      3

// local event status bits: 0 host-to-local irq raised, 1 host irq pin asserted
`define PSSB_EV_H2L         0
`define PSSB_EV_HOSTIRQ     1
`define PSSB_EV_W           2

`endif

// ### hdl/pssb_status_bank.v
// status set/clear register bank with level pins and wishbone slave
//
// Design decisions made here: the address map and the Wishbone slave port.
`include "pssb_defines.vh"
`default_nettype none

module pssb_status_bank (
    input  wire        clk_i,
    input  wire        srst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [4:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        parity_error_i,
    input  wire        system_error_i,
    input  wire        master_abort_i,
    input  wire        target_abort_i,
    input  wire        power_d0_i,
    output reg  [31:0] status_o,
    output reg  [31:0] status_local_o,
    output reg         host_to_local_irq_o,
    output reg         host_irq_pin_n_o,
    output reg         parity_error_pin_n_o,
    output reg         system_error_pin_n_o,
    output reg         irq_o
);

    // byte-lane expansion, used for the force, drop and enable registers
    function [31:0] lane_mask;
        input [3:0] sel;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                lane_mask[k*8 +: 8] = {8{sel[k]}};
            end
        end
    endfunction

    function reg_hit;
        input [4:0] adr;
        input [4:0] target;
        begin
            reg_hit = (adr[4:2] == target[4:2]);
        end
    endfunction

    // pin-side conditions pass two flops before use
    reg  [3:0]  cond_meta;
    reg  [3:0]  cond_sync;
    wire [31:0] hw_cond;

    reg  [31:0] status;
    reg  [31:0] host_enable;
    reg  [31:0] local_enable;
    reg  [`PSSB_EV_W-1:0] ev_status;
    reg  [`PSSB_EV_W-1:0] ev_mask;
    reg  [1:0]  d0_sync;

    reg  [31:0] pipe1;
    reg  [31:0] pipe2;

    reg  [31:0] next_status;
    reg  [31:0] sw_clear;
    reg  [31:0] wmask;
    reg         prev_h2l;
    reg         prev_hirq;
    reg  [`PSSB_EV_W-1:0] ev_raise;

    wire        wr_stb;
    wire        host_irq_now;

    assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

    assign hw_cond = {25'h000_0000, cond_sync[3], cond_sync[2], 2'b00,
                      cond_sync[1], cond_sync[0], 1'b0};

    always @(posedge clk_i) begin
        if (srst_i) begin
            cond_meta <= 4'h0;
            cond_sync <= 4'h0;
            d0_sync   <= 2'b00;
        end else begin
            cond_meta <= {parity_error_i, system_error_i, master_abort_i, target_abort_i};
            cond_sync <= cond_meta;
            d0_sync   <= {d0_sync[0], power_d0_i};
        end
    end

    // status next-state: hardware causes win over clears, and clears are applied after software sets
    always @* begin
        wmask           = lane_mask(wb_sel_i) & wb_dat_i & `PSSB_STATUS_MASK;
        next_status     = status;
        sw_clear        = 32'h0000_0000;
        if (wr_stb && reg_hit(wb_adr_i, `PSSB_ADR_FORCE)) begin
            next_status = status | wmask;
            if (!local_enable[`PSSB_BIT_HOST2LOC]) begin
                next_status[`PSSB_BIT_HOST2LOC] = status[`PSSB_BIT_HOST2LOC];
            end
        end
        if (wr_stb && reg_hit(wb_adr_i, `PSSB_ADR_DROP)) begin
            sw_clear = wmask;
        end
        // a bit with its cause still asserted refuses the clear
        next_status     = (next_status & ~(sw_clear & ~hw_cond)) | hw_cond;
        next_status     = next_status & `PSSB_STATUS_MASK;
    end

    // forced bits ignore the cause going away; only the clear alias drops them
    always @(posedge clk_i) begin
        if (srst_i) begin
            status     <= `PSSB_STATUS_RESET;
        end else begin
            status     <= next_status;
        end
    end

    // enables: host enable and local enable are plain rw here
    always @(posedge clk_i) begin
        if (srst_i) begin
            host_enable  <= 32'h0000_0000;
            local_enable <= 32'h0000_0000;
            ev_mask      <= {`PSSB_EV_W{1'b0}};
        end else if (wr_stb) begin
            if (reg_hit(wb_adr_i, `PSSB_ADR_HOSTEN)) begin
                host_enable <= (host_enable & ~lane_mask(wb_sel_i))
                             | (wb_dat_i & lane_mask(wb_sel_i) & `PSSB_STATUS_MASK);
            end
            if (reg_hit(wb_adr_i, `PSSB_ADR_BEEN)) begin
                local_enable <= (local_enable & ~lane_mask(wb_sel_i))
                              | (wb_dat_i & lane_mask(wb_sel_i) & `PSSB_STATUS_MASK);
            end
            if (reg_hit(wb_adr_i, `PSSB_ADR_IRQ_MASK) && wb_sel_i[0]) begin
                ev_mask <= wb_dat_i[`PSSB_EV_W-1:0];
            end
        end
    end

    // three-stage delay of the status into the local domain copy
    always @(posedge clk_i) begin
        if (srst_i) begin
            pipe1          <= 32'h0000_0000;
            pipe2          <= 32'h0000_0000;
            status_local_o <= 32'h0000_0000;
        end else begin
            pipe1          <= status;
            pipe2          <= pipe1;
            status_local_o <= pipe2;
        end
    end

    assign host_irq_now = d0_sync[1] & |(status & host_enable);

    // error pins follow the status level, so they drop only once cause and flag are gone
    always @(posedge clk_i) begin
        if (srst_i) begin
            status_o             <= 32'h0000_0000;
            host_irq_pin_n_o     <= 1'b1;
            parity_error_pin_n_o <= 1'b1;
            system_error_pin_n_o <= 1'b1;
            host_to_local_irq_o  <= 1'b0;
        end else begin
            status_o             <= status;
            host_irq_pin_n_o     <= ~host_irq_now;
            parity_error_pin_n_o <= ~status[`PSSB_BIT_PARITY];
            system_error_pin_n_o <= ~status[`PSSB_BIT_SYSERR];
            host_to_local_irq_o  <= |(status_local_o & local_enable);
        end
    end

    // local interrupt events: rising edges, sticky, write one to clear
    always @* begin
        ev_raise = {`PSSB_EV_W{1'b0}};
        ev_raise[`PSSB_EV_H2L]     = host_to_local_irq_o & ~prev_h2l;
        ev_raise[`PSSB_EV_HOSTIRQ] = ~host_irq_pin_n_o & ~prev_hirq;
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            prev_h2l  <= 1'b0;
            prev_hirq <= 1'b0;
            ev_status <= {`PSSB_EV_W{1'b0}};
            irq_o     <= 1'b0;
        end else begin
            prev_h2l  <= host_to_local_irq_o;
            prev_hirq <= ~host_irq_pin_n_o;
            if (wr_stb && reg_hit(wb_adr_i, `PSSB_ADR_IRQ_STAT) && wb_sel_i[0]) begin
                ev_status <= (ev_status & ~wb_dat_i[`PSSB_EV_W-1:0]) | ev_raise;
            end else begin
                ev_status <= ev_status | ev_raise;
            end
            irq_o     <= |(ev_status & ev_mask);
        end
    end

    // wishbone classic: ack one cycle after strobe, dropped the next cycle
    always @(posedge clk_i) begin
        if (srst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
                case (wb_adr_i[4:2])
                    3'd0, 3'd1: wb_dat_o <= status;
                    3'd2:       wb_dat_o <= host_enable;
                    3'd3:       wb_dat_o <= local_enable;
                    3'd4:       wb_dat_o <= {{(32-`PSSB_EV_W){1'b0}}, ev_status};
                    3'd5:       wb_dat_o <= {{(32-`PSSB_EV_W){1'b0}}, ev_mask};
                    3'd6:       wb_dat_o <= {{31{1'b0}}, d0_sync[1]};
                    default:    wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ### tb/pssb_status_bank_assertions.sv
// port checker for the status set/clear bank
`default_nettype none
module pssb_sva (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [4:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        parity_error_i,
    input wire logic        power_d0_i,
    input wire logic [31:0] status_o,
    input wire logic [31:0] status_local_o,
    input wire logic        host_irq_pin_n_o,
    input wire logic        parity_error_pin_n_o,
    input wire logic        system_error_pin_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_ack_latency: assert property (req |=> wb_ack_o) else $error("ack late");
    chk_rsvd_zero: assert property ((status_o & ~32'h8F00_0066) == 0)
        else $error("reserved bit set");
    chk_parity_pin: assert property (parity_error_pin_n_o == !status_o[6])
        else $error("parity pin wrong");
    chk_syserr_pin: assert property (system_error_pin_n_o == !status_o[5])
        else $error("system pin wrong");
    chk_local_delay: assert property (!$past(srst_i, 2) && !$past(srst_i)
        |-> status_local_o == $past(status_o, 2)) else $error("local copy timing");
    chk_force_bits: assert property (
        req && wb_we_i && wb_adr_i[4:2] == 3'h0 &&
        wb_sel_i == 4'hF |-> ##2 (status_o & $past(wb_dat_i, 2) & 32'h0F00_0066)
        == ($past(wb_dat_i, 2) & 32'h0F00_0066)) else $error("set alias missed");
    chk_read_status: assert property (req && !wb_we_i && wb_adr_i[4:3] == 2'h0
        |=> wb_dat_o == status_o) else $error("alias read wrong");
    chk_cause_held: assert property (parity_error_i [*6] |-> status_o[6])
        else $error("flag dropped under cause");
    chk_host_off: assert property (!power_d0_i [*5] |-> host_irq_pin_n_o)
        else $error("host pin outside D0");
endmodule
bind pssb_status_bank pssb_sva u_sva (.clk_i, .srst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .parity_error_i, .power_d0_i,
    .status_o, .status_local_o, .host_irq_pin_n_o, .parity_error_pin_n_o,
    .system_error_pin_n_o);
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the status set/clear bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, srst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [4:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, status_o, status_local_o, q, d, e;
    logic        parity_error_i, system_error_i, master_abort_i, target_abort_i, power_d0_i;
    logic        host_to_local_irq_o, host_irq_pin_n_o, parity_error_pin_n_o;
    logic        system_error_pin_n_o, irq_o;
    int          n_errors = 0;
    int          n_compared = 0;
    logic [31:0] bm [4] = '{32'h0000_0040, 32'h0000_0020, 32'h0000_0004, 32'h0000_0002};
    pssb_status_bank uut (.clk_i, .srst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .parity_error_i, .system_error_i,
        .master_abort_i, .target_abort_i, .power_d0_i, .status_o, .status_local_o,
        .host_to_local_irq_o, .host_irq_pin_n_o, .parity_error_pin_n_o,
        .system_error_pin_n_o, .irq_o);
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // entered just after a rising edge; request held until ack is sampled
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dd);
        int t = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= dd;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++t < 50);
        if (t == 50)
            chk("bus ack", 32'h0000_0001, 32'h0000_0000);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0000_0000);
        chk("read data", x, q);
    endtask
    // bit 31 stays out: its local enable is off during the random phase
    function automatic logic [31:0] nxt(logic [31:0] s, logic [31:0] v, logic clr);
        return clr ? s & ~v : s | (v & 32'h0F00_0066);
    endfunction
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {parity_error_i, system_error_i, master_abort_i, target_abort_i, power_d0_i} = '0;
        wb_sel_i = 4'hF;
        srst_i = 1'b1;
        void'($urandom(93558));
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        rd(5'h00, 32'h0000_0000);
        bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
        rd(5'h1C, 32'h0000_0000);
        $display("reset test done");
        e = 32'h0000_0000;
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $urandom();
            bus(1'b1, {2'h0, i[0], 2'h0}, d);
            e = nxt(e, d, i[0]);
            rd({2'h0, i[1], 2'h0}, e);
        end
        $display("random set clear test done");
        bus(1'b1, 5'h0C, 32'h8000_0000);
        bus(1'b1, 5'h00, 32'h8000_0000);
        rd(5'h00, e | 32'h8000_0000);
        repeat (6) @(posedge clk_i);
        chk("local irq", 32'h0000_0001, 32'(host_to_local_irq_o));
        bus(1'b1, 5'h04, 32'hFFFF_FFFF);
        rd(5'h00, 32'h0000_0000);
        repeat (6) @(posedge clk_i);
        chk("local copy", 32'h0000_0000, status_local_o);
        $display("irq bit test done");
        for (int k = 0; k < 4; k++) begin
            {parity_error_i, system_error_i, master_abort_i, target_abort_i} <= 4'h8 >> k;
            repeat (6) @(posedge clk_i);
            bus(1'b1, 5'h04, bm[k]);
            rd(5'h04, bm[k]);
            d = 32'({parity_error_pin_n_o, system_error_pin_n_o});
            chk("error pins", 32'({~bm[k][6], ~bm[k][5]}), d);
            {parity_error_i, system_error_i, master_abort_i, target_abort_i} <= 4'h0;
            repeat (4) @(posedge clk_i);
            rd(5'h00, bm[k]);
            bus(1'b1, 5'h04, bm[k]);
            rd(5'h00, 32'h0000_0000);
        end
        $display("cause test done");
        bus(1'b1, 5'h08, 32'h0100_0000);
        power_d0_i <= 1'b1;
        bus(1'b1, 5'h14, 32'h0000_0002);
        bus(1'b1, 5'h00, 32'h0100_0000);
        rd(5'h08, 32'h0100_0000);
        rd(5'h18, 32'h0000_0001);
        repeat (6) @(posedge clk_i);
        chk("host pin", 32'h0000_0000, 32'(host_irq_pin_n_o));
        chk("irq", 32'h0000_0001, 32'(irq_o));
        power_d0_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("host pin", 32'h0000_0001, 32'(host_irq_pin_n_o));
        rd(5'h18, 32'h0000_0000);
        bus(1'b1, 5'h14, 32'h0000_0000);
        repeat (2) @(posedge clk_i);
        chk("irq", 32'h0000_0000, 32'(irq_o));
        bus(1'b1, 5'h10, 32'h0000_0003);
        bus(1'b1, 5'h14, 32'h0000_0003);
        repeat (2) @(posedge clk_i);
        chk("irq", 32'h0000_0000, 32'(irq_o));
        $display("host irq test done");
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
